/* File: dv/tdac_acq_ctrl_tb_top.sv */
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ns
module tdac_acq_ctrl_tb_top;
	logic        clk         = 1'b0;
	logic        rst         = 1'b1;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [7:0]  paddr       = 8'h00;
	logic [31:0] pwdata      = 32'h0;
	logic        ext_clk_in  = 1'b0;
	logic        ext_trig_in = 1'b0;
	logic [2:0]  mem_size_sw = 3'h0;
	logic [6:0]  salt        = 7'h00;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        th_hold;
	logic        adc_start;
	logic [4:0]  adc_chan;
	logic        adc_done;
	logic [11:0] adc_data;
	logic        mem_we;
	logic [19:0] mem_addr;
	logic [11:0] mem_wdata;
	logic [31:0] exp_q [$];
	logic [31:0] rd;
	logic        err;
	int          bad_count   = 0;
	int          n_compared  = 0;
	int          cycles      = 0;
	int          lat [2];
	int          n;

	// divider counts shrunk fifty-fold so the slow rates fit the run
	tdac_acq_ctrl #(.CLK_HZ(1_000_000)) tdac_acq_ctrl_i (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clk_in(ext_clk_in), .ext_trig_in(ext_trig_in),
		.mem_size_sw(mem_size_sw), .th_hold(th_hold), .adc_start(adc_start),
		.adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));

	tdac_adc_model tdac_adc_model_i (
		.clk(clk), .rst(rst), .adc_start(adc_start), .adc_chan(adc_chan),
		.salt(salt), .adc_done(adc_done), .adc_data(adc_data));

	initial begin
		forever #10 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD t=%0t seen %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic give_verdict();
		if (bad_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	// one transfer: setup, then access held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// note one set: channel k of the set lands at base plus k
	task automatic expect_set(input int cnt, input int base);
		for (int ch = 0; ch < cnt; ch++) begin
			exp_q.push_back({20'(base + ch), salt, 5'(ch)});
		end
	endtask : expect_set

	// one external sample edge, then room for scan and the 5N+5 guard
	task automatic pulse_ext();
		ext_clk_in <= 1'b1;
		repeat (3) @(posedge clk);
		ext_clk_in <= 1'b0;
		for (int i = 0; i < 20 && th_hold !== 1'b1; i++) @(posedge clk);
		while (th_hold === 1'b1) @(posedge clk);
		repeat (180) @(posedge clk);
	endtask : pulse_ext

	// every memory write must match the oldest noted word; none unnoted
	always @(posedge clk) begin
		if (mem_we === 1'b1 && exp_q.size() == 0) begin
			check({mem_addr, mem_wdata}, 32'h0);
		end else if (mem_we === 1'b1) begin
			check({mem_addr, mem_wdata}, exp_q.pop_front());
		end
	end

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			give_verdict();
		end
	end

	initial begin
		void'($urandom(87865));
		mem_size_sw <= 3'($urandom_range(7, 0));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, tdac_pkg::OFS_STATUS, 32'h0);
		check(rd, 32'h0000_0030);
		apb(1'b0, 8'h18, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		// every channel count in pre-trigger mode on the external clock
		for (int code = 0; code < 4; code++) begin
			n = 4 << code;
			salt <= 7'($urandom);
			apb(1'b1, tdac_pkg::OFS_POSTCNT, 32'h1);
			apb(1'b1, tdac_pkg::OFS_CTRL, 32'h7 | (32'(code) << 12));
			apb(1'b0, tdac_pkg::OFS_STATUS, 32'h0);
			check(rd & 32'h31, 32'(code) << 4);
			expect_set(n, 0);
			pulse_ext();
			// trigger placed between sample edges; both sources alternate
			if (code[0]) begin
				apb(1'b1, tdac_pkg::OFS_CTRL, 32'h10);
			end else begin
				ext_trig_in <= 1'b1;
				repeat (3) @(posedge clk);
				ext_trig_in <= 1'b0;
				repeat (10) @(posedge clk);
			end
			expect_set(n, n);
			pulse_ext();
			pulse_ext();
			check(32'(exp_q.size()), 32'h0);
			apb(1'b0, tdac_pkg::OFS_STATUS, 32'h0);
			check(rd & 32'h31, (32'(code) << 4) | 32'h1);
			apb(1'b0, tdac_pkg::OFS_VALID, 32'h0);
			check(rd, 32'h2);
			apb(1'b0, tdac_pkg::OFS_PTR, 32'h0);
			check(rd, 32'(2 * n));
			apb(1'b0, tdac_pkg::OFS_OLDEST, 32'h0);
			check(rd, 32'h0);
		end
		// post-trigger, internal clock at the slowest rate, stopped by host
		for (int run = 0; run < 2; run++) begin
			apb(1'b1, tdac_pkg::OFS_CTRL, 32'h0000_0801);
			repeat (100) @(posedge clk);
			expect_set(4, 0);
			apb(1'b1, tdac_pkg::OFS_CTRL, 32'h10);
			lat[run] = 0;
			while (adc_start !== 1'b1 && lat[run] < 10100) begin
				@(posedge clk);
				lat[run]++;
			end
			while (th_hold === 1'b1) @(posedge clk);
			repeat (10) @(posedge clk);
			apb(1'b1, tdac_pkg::OFS_CTRL, 32'h8);
			apb(1'b0, tdac_pkg::OFS_STATUS, 32'h0);
			check(rd & 32'h33, 32'h1);
			apb(1'b0, tdac_pkg::OFS_VALID, 32'h0);
			check(rd, 32'h1);
		end
		check(32'(lat[0]), 32'(lat[1]));
		check(32'(lat[0] < 10000), 32'h1);
		check(32'(exp_q.size()), 32'h0);
		give_verdict();
	end
endmodule : tdac_acq_ctrl_tb_top

/* File: dv/tdac_adc_model.sv */
// converter model standing in for the far side of the scan interface
`timescale 1ns/1ns
module tdac_adc_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        adc_start,
	input  wire logic [4:0]  adc_chan,
	input  wire logic [6:0]  salt,
	output logic             adc_done,
	output logic      [11:0] adc_data
);
	logic [2:0] wait_reg;
	logic       busy_reg;
	logic [4:0] chan_reg;

	// answer 1..4 cycles late so prompt and slow conversions both occur
	always_ff @(posedge clk) begin
		adc_done <= 1'b0;
		adc_data <= ~adc_data; // stale bus toggles so no old word can pass
		if (rst) begin
			busy_reg <= 1'b0;
			adc_data <= 12'h000;
		end else if (adc_start) begin
			busy_reg <= 1'b1;
			chan_reg <= adc_chan;
			wait_reg <= 3'($urandom_range(3, 0));
		end else if (busy_reg && wait_reg != 3'h0) begin
			wait_reg <= wait_reg - 3'h1;
		end else if (busy_reg) begin
			busy_reg <= 1'b0;
			adc_done <= 1'b1;
			adc_data <= {salt, chan_reg}; // word names its channel for ordering checks
		end
	end
endmodule : tdac_adc_model

/* File: hw/tdac_acq_ctrl.sv */
// acquisition sequencer: sample clock, trigger, scan and memory addressing
// Function
// - host selects 32, 16, 8 or 4 active channels; only those are scanned
// - sample sets no closer than 5 us per channel plus 5 us
// - each sample clock puts all active track-and-holds in hold, then scans
// - words written in channel order, first through last active channel
// - sample clock comes from internal divider or external clock pin
// - memory address reaches up to one megaword
// - usable memory size taken from board switches
// - active channel count held in host-loaded status bits
// - post-trigger arming clears address to zero, waits for trigger
// - post-trigger run ends when memory full or on host stop
// - post-trigger internal clock: first set a fixed delay after trigger
// - at end, set record_complete_flag and ignore clocks and triggers
// - pre-trigger arming starts storing at once, overwriting circularly
// - post-trigger sample count supplied by host, latched at arming
// - after trigger plus count, stop, flag completion, save next address once memory has wrapped, else zero
// - saved address is oldest stored channel-zero sample
// - valid counter clears on arm, counts channel-zero samples, saturates
// - pre-trigger mode acts on first trigger only until re-armed
// - pre-trigger internal clock never disturbed by the trigger
// - panel trigger and host trigger are ORed into one event
// - internal rates 40, 20, 10, 5, 2, 1, 0.5, 0.2, 0.1 kHz
`timescale 1ns/1ns
module tdac_acq_ctrl #(
	parameter int unsigned CLK_HZ = tdac_pkg::CLK_HZ
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_clk_in,
	input  wire logic        ext_trig_in,
	input  wire logic [2:0]  mem_size_sw,
	output logic             th_hold,
	output logic             adc_start,
	output logic      [4:0]  adc_chan,
	input  wire logic        adc_done,
	input  wire logic [11:0] adc_data,
	output logic             mem_we,
	output logic      [19:0] mem_addr,
	output logic      [11:0] mem_wdata
);
	// least time rounds up to whole cycles
	localparam int unsigned US_CYC = (CLK_HZ + tdac_pkg::HZ_PER_MHZ - 1) / tdac_pkg::HZ_PER_MHZ;

	logic [4:0]  sync_a_reg;
	logic [4:0]  sync_b_reg;
	logic        clk_d_reg;
	logic        trig_d_reg;
	logic        armed_reg;
	logic        done_reg;
	logic        pre_reg;
	logic        ext_reg;
	logic [3:0]  rate_reg;
	logic [1:0]  chan_reg;
	logic [2:0]  size_reg;
	logic [19:0] postcnt_reg;
	logic [19:0] postlat_reg;
	logic [19:0] post_sets_reg;
	logic        trig_seen_reg;
	logic [19:0] div_cnt_reg;
	logic [15:0] guard_reg;
	logic [19:0] addr_reg;
	logic [20:0] valid_reg;
	logic [19:0] oldest_reg;
	logic        set_end_reg;
	tdac_pkg::tdac_scan_t state_reg;

	logic        acc;
	logic        wr;
	logic        hit;
	logic        arm_wr;
	logic        stop_wr;
	logic        swtrig_wr;
	logic        ext_rise;
	logic        trig_evt;
	logic        run;
	logic        waiting;
	logic        int_tick;
	logic        sample_clk;
	logic        accept;
	logic        finish;
	logic        conv_done;
	logic [5:0]  n_ch;
	logic [4:0]  last_ch;
	logic [19:0] mask;
	logic [20:0] sets_max;
	logic [19:0] div_top;
	logic [15:0] guard_top;
	logic [3:0]  rsel;
	logic [31:0] rd_mux;

	// two flops on every pin input; stage a feeds only stage b
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_a_reg <= 5'h00;
			sync_b_reg <= 5'h00;
			clk_d_reg  <= 1'b0;
			trig_d_reg <= 1'b0;
		end else begin
			sync_a_reg <= {mem_size_sw, ext_trig_in, ext_clk_in};
			sync_b_reg <= sync_a_reg;
			clk_d_reg  <= sync_b_reg[0];
			trig_d_reg <= sync_b_reg[1];
		end
	end

	// bus decode; zero wait states, unmapped offsets answer with an error
	assign acc       = psel & penable;
	assign wr        = acc & pwrite;
	assign hit       = (paddr == tdac_pkg::OFS_CTRL) || (paddr == tdac_pkg::OFS_POSTCNT) ||
		(paddr == tdac_pkg::OFS_STATUS) || (paddr == tdac_pkg::OFS_OLDEST) ||
		(paddr == tdac_pkg::OFS_VALID) || (paddr == tdac_pkg::OFS_PTR);
	assign pready    = 1'b1;
	assign pslverr   = acc & ~hit;
	assign arm_wr    = wr & (paddr == tdac_pkg::OFS_CTRL) & pwdata[tdac_pkg::CTRL_ARM];
	assign stop_wr   = wr & (paddr == tdac_pkg::OFS_CTRL) & pwdata[tdac_pkg::CTRL_STOP];
	assign swtrig_wr = wr & (paddr == tdac_pkg::OFS_CTRL) & pwdata[tdac_pkg::CTRL_TRIG];

	// event sources
	assign ext_rise = sync_b_reg[0] & ~clk_d_reg;
	assign trig_evt = (sync_b_reg[1] & ~trig_d_reg) | swtrig_wr;
	assign run      = armed_reg & ~done_reg;
	assign waiting  = run & ~pre_reg & ~trig_seen_reg;

	// derived geometry
	assign n_ch     = 6'd4 << chan_reg;
	assign last_ch  = 5'(n_ch - 6'd1);
	assign mask     = tdac_pkg::MEM_MASK_FULL >> (tdac_pkg::MEM_SW_MAX - size_reg);
	assign sets_max = ({1'b0, mask} + 21'd1) >> ({1'b0, chan_reg} + 3'd2);
	assign rsel     = (rate_reg > 4'(tdac_pkg::RATE_CODE_MAX)) ?
		4'(tdac_pkg::RATE_CODE_MAX) : rate_reg;

	// divider top and scan guard from rate and channel count
	always_comb begin
		div_top   = 20'(CLK_HZ / tdac_pkg::RATE_HZ[rsel] - 1);
		guard_top = 16'(US_CYC * (tdac_pkg::SCAN_US_PER_CH * n_ch + tdac_pkg::SCAN_US_BASE));
	end

	// setup, mode and latched settings; an arming write reloads all but postcnt_reg, which its own offset write loads
	always_ff @(posedge clk) begin
		if (rst) begin
			pre_reg     <= 1'b0;
			ext_reg     <= 1'b0;
			rate_reg    <= tdac_pkg::RATE_RST;
			chan_reg    <= tdac_pkg::CHAN_RST;
			size_reg    <= 3'h0;
			postcnt_reg <= tdac_pkg::POSTCNT_RST;
			postlat_reg <= tdac_pkg::POSTCNT_RST;
		end else begin
			if (wr && paddr == tdac_pkg::OFS_POSTCNT)
				postcnt_reg <= pwdata[19:0];
			if (arm_wr) begin
				pre_reg     <= pwdata[tdac_pkg::CTRL_PRE];
				ext_reg     <= pwdata[tdac_pkg::CTRL_EXTCLK];
				rate_reg    <= pwdata[tdac_pkg::CTRL_RATE_LSB +: 4];
				chan_reg    <= pwdata[tdac_pkg::CTRL_CHAN_LSB +: 2];
				size_reg    <= sync_b_reg[4:2];
				postlat_reg <= postcnt_reg;
			end
		end
	end

	// arm and completion; a completing event wins over a clear
	always_ff @(posedge clk) begin
		if (rst) begin
			armed_reg <= 1'b0;
			done_reg  <= 1'b0;
		end else begin
			if (arm_wr)
				armed_reg <= 1'b1;
			done_reg <= finish | (done_reg & ~arm_wr);
		end
	end

	// first trigger only; later ones ignored until re-armed
	always_ff @(posedge clk) begin
		if (rst || arm_wr)
			trig_seen_reg <= 1'b0;
		else if (run && trig_evt)
			trig_seen_reg <= 1'b1;
	end

	// internal clock; parked at its top while a post-trigger run waits,
	// so the first tick follows the trigger by a fixed latency
	always_ff @(posedge clk) begin
		if (rst)
			div_cnt_reg <= 20'h00000;
		else if (!run || waiting)
			div_cnt_reg <= div_top;
		else if (div_cnt_reg >= div_top)
			div_cnt_reg <= 20'h00000;
		else
			div_cnt_reg <= div_cnt_reg + 20'h00001;
	end

	assign int_tick   = run & ~waiting & (div_cnt_reg >= div_top);
	assign sample_clk = ext_reg ? ext_rise : int_tick;
	// a clock landing inside the guard or a running scan is dropped
	assign accept     = run & (pre_reg | trig_seen_reg) & sample_clk &
		(state_reg == tdac_pkg::SC_IDLE) & (guard_reg == 16'h0000);
	assign conv_done  = (state_reg == tdac_pkg::SC_WAIT) & adc_done;

	// least spacing between sample sets
	always_ff @(posedge clk) begin
		if (rst || arm_wr)
			guard_reg <= 16'h0000;
		else if (accept)
			guard_reg <= guard_top - 16'h0001;
		else if (guard_reg != 16'h0000)
			guard_reg <= guard_reg - 16'h0001;
	end

	// scan: hold all, convert each channel in turn, write each word
	always_ff @(posedge clk) begin
		if (rst || arm_wr || finish) begin
			state_reg   <= tdac_pkg::SC_IDLE;
			th_hold     <= 1'b0;
			adc_start   <= 1'b0;
			adc_chan    <= 5'h00;
			mem_we      <= 1'b0;
			set_end_reg <= 1'b0;
		end else begin
			adc_start   <= 1'b0;
			mem_we      <= 1'b0;
			set_end_reg <= 1'b0;
			unique case (state_reg)
				tdac_pkg::SC_IDLE: begin
					if (accept) begin
						th_hold   <= 1'b1;
						adc_chan  <= 5'h00;
						adc_start <= 1'b1;
						state_reg <= tdac_pkg::SC_WAIT;
					end
				end
				tdac_pkg::SC_WAIT: begin
					if (adc_done) begin
						mem_we <= 1'b1;
						if (adc_chan == last_ch) begin
							th_hold     <= 1'b0;
							set_end_reg <= 1'b1;
							state_reg   <= tdac_pkg::SC_IDLE;
						end else begin
							state_reg <= tdac_pkg::SC_NEXT;
						end
					end
				end
				tdac_pkg::SC_NEXT: begin
					adc_chan  <= adc_chan + 5'h01;
					adc_start <= 1'b1;
					state_reg <= tdac_pkg::SC_WAIT;
				end
			endcase
		end
	end

	// memory word and address; pointer is the next free word
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_addr  <= 20'h00000;
			mem_wdata <= 12'h000;
			addr_reg  <= 20'h00000;
		end else if (arm_wr) begin
			addr_reg <= 20'h00000;
		end else if (conv_done) begin
			mem_addr  <= addr_reg;
			mem_wdata <= adc_data;
			addr_reg  <= (addr_reg + 20'h00001) & mask;
		end
	end

	// valid sample sets; stops at the memory's set capacity
	always_ff @(posedge clk) begin
		if (rst || arm_wr)
			valid_reg <= 21'h000000;
		else if (conv_done && adc_chan == 5'h00 && valid_reg < sets_max)
			valid_reg <= valid_reg + 21'h000001;
	end

	// sets completed since the trigger
	always_ff @(posedge clk) begin
		if (rst || arm_wr)
			post_sets_reg <= 20'h00000;
		else if (set_end_reg && trig_seen_reg)
			post_sets_reg <= post_sets_reg + 20'h00001;
	end

	// end of sequence: memory full in post mode, count reached in pre mode
	assign finish = run & (stop_wr | (set_end_reg & (pre_reg ?
		(trig_seen_reg & (post_sets_reg + 20'h00001 >= postlat_reg)) :
		(addr_reg == 20'h00000))));

	// oldest channel-zero word: the next address once memory has wrapped
	always_ff @(posedge clk) begin
		if (rst)
			oldest_reg <= 20'h00000;
		else if (finish)
			oldest_reg <= (valid_reg >= sets_max) ? addr_reg : 20'h00000;
	end

	// read data mux, captured in the setup cycle
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (paddr)
			tdac_pkg::OFS_CTRL: begin
				rd_mux[tdac_pkg::CTRL_PRE]           = pre_reg;
				rd_mux[tdac_pkg::CTRL_EXTCLK]        = ext_reg;
				rd_mux[tdac_pkg::CTRL_RATE_LSB +: 4] = rate_reg;
				rd_mux[tdac_pkg::CTRL_CHAN_LSB +: 2] = chan_reg;
			end
			tdac_pkg::OFS_POSTCNT: rd_mux[19:0] = postcnt_reg;
			tdac_pkg::OFS_STATUS: begin
				rd_mux[tdac_pkg::STS_DONE]          = done_reg;
				rd_mux[tdac_pkg::STS_RUN]           = run;
				rd_mux[tdac_pkg::STS_TRIG]          = trig_seen_reg;
				rd_mux[tdac_pkg::STS_BUSY]          = th_hold;
				rd_mux[tdac_pkg::STS_CHAN_LSB +: 2] = chan_reg;
				rd_mux[tdac_pkg::STS_FULL]          = valid_reg >= sets_max;
			end
			tdac_pkg::OFS_OLDEST: rd_mux[19:0] = oldest_reg;
			tdac_pkg::OFS_VALID:  rd_mux[20:0] = valid_reg;
			tdac_pkg::OFS_PTR:    rd_mux[19:0] = addr_reg;
			default:              rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	hold_all_a: assert property (accept |=> th_hold && adc_start && adc_chan == 5'h00)
		else $error("hold or scan start missing after sample clock");
	chan_order_a: assert property (state_reg == tdac_pkg::SC_NEXT && !arm_wr && !finish |=>
		adc_start && adc_chan == $past(adc_chan) + 5'h01)
		else $error("channels not scanned in order");
	chan_limit_a: assert property (mem_we |-> adc_chan <= last_ch)
		else $error("inactive channel written");
	arm_clear_a: assert property (arm_wr && !stop_wr |=>
		addr_reg == 20'h00000 && !done_reg && valid_reg == 21'h000000)
		else $error("arming did not clear state");
	// an arming write may switch to pre mode, which samples at once
	post_wait_a: assert property (waiting && !trig_evt && !arm_wr |=> !th_hold [*2])
		else $error("post mode sampled before trigger");
	done_quiet_a: assert property (done_reg && !arm_wr |=> !adc_start && !mem_we)
		else $error("activity after record complete");
	first_tick_a: assert property (waiting && trig_evt && !ext_reg && !arm_wr && !stop_wr |=>
		int_tick)
		else $error("first sample not one cycle after trigger");
	guard_gap_a: assert property (accept |=> guard_reg == $past(guard_top) - 16'h0001)
		else $error("sample guard not loaded");
	valid_sat_a: assert property (valid_reg >= sets_max |=>
		valid_reg == $past(valid_reg) || $past(arm_wr))
		else $error("valid counter rolled past capacity");
	trig_once_a: assert property (trig_seen_reg && !arm_wr |=>
		trig_seen_reg && post_sets_reg >= $past(post_sets_reg))
		else $error("trigger state disturbed before re-arm");
	addr_wrap_a: assert property (mem_we |-> addr_reg == ((mem_addr + 20'h00001) & mask))
		else $error("address not consecutive or wrap wrong");
	oldest_a: assert property ($rose(done_reg) |->
		oldest_reg == ((valid_reg >= sets_max) ? addr_reg : 20'h00000))
		else $error("oldest address wrong at end of record");
endmodule : tdac_acq_ctrl

/* File: hw/tdac_pkg.sv */
// constants and types shared by the digitizer acquisition sequencer
package tdac_pkg;
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned ADDR_W          = 20;
	localparam int unsigned DATA_W          = 12;
	localparam int unsigned CH_W            = 5;
	localparam int unsigned PADDR_W         = 8;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_POSTCNT     = 8'h04;
	localparam logic [7:0]  OFS_STATUS      = 8'h08;
	localparam logic [7:0]  OFS_OLDEST      = 8'h0c;
	localparam logic [7:0]  OFS_VALID       = 8'h10;
	localparam logic [7:0]  OFS_PTR         = 8'h14;
	// control word fields
	localparam int unsigned CTRL_ARM        = 0;
	localparam int unsigned CTRL_PRE        = 1;
	localparam int unsigned CTRL_EXTCLK     = 2;
	localparam int unsigned CTRL_STOP       = 3;
	localparam int unsigned CTRL_TRIG       = 4;
	localparam int unsigned CTRL_RATE_LSB   = 8;
	localparam int unsigned CTRL_CHAN_LSB   = 12;
	// status word fields
	localparam int unsigned STS_DONE        = 0;
	localparam int unsigned STS_RUN         = 1;
	localparam int unsigned STS_TRIG        = 2;
	localparam int unsigned STS_BUSY        = 3;
	localparam int unsigned STS_CHAN_LSB    = 4;
	localparam int unsigned STS_FULL        = 6;
	// reset values
	localparam logic [3:0]  RATE_RST        = 4'h0;
	localparam logic [1:0]  CHAN_RST        = 2'h3;
	localparam logic [19:0] POSTCNT_RST     = 20'h00000;
	// sampling rates in Hz, selected by code 0..8
	localparam int unsigned RATE_CODE_MAX   = 8;
	localparam int unsigned RATE_HZ [9]     = '{40_000, 20_000, 10_000, 5_000, 2_000,
		1_000, 500, 200, 100};
	// least sample period: 5 us per active channel plus 5 us
	localparam int unsigned SCAN_US_PER_CH  = 5;
	localparam int unsigned SCAN_US_BASE    = 5;
	localparam int unsigned HZ_PER_MHZ      = 1_000_000;
	// memory: switch code k gives 2^(13+k) words, up to 2^20
	localparam logic [2:0]  MEM_SW_MAX      = 3'h7;
	localparam logic [19:0] MEM_MASK_FULL   = 20'hfffff;

	typedef enum logic [2:0] {
		SC_IDLE = 3'b001,
		SC_WAIT = 3'b010,
		SC_NEXT = 3'b100
	} tdac_scan_t;
endpackage : tdac_pkg
